/* bpc_top.sv */
// Control register, status byte and protection sequencing of the pack protector
`timescale 1ns/1ns
`default_nettype none
module bpc_top #(
  parameter int unsigned PERIOD_CYC = bpc_pkg::SAMPLE_PERIOD_CYC,
  parameter int unsigned WINDOW_CYC = bpc_pkg::SAMPLE_WINDOW_CYC
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic ov_trip,
  input wire logic ov_release,
  input wire logic uv_trip,
  input wire logic uv_release,
  input wire logic oc_trip,
  input wire logic oc_release,
  input wire logic regulator_tuned,
  input wire logic low_cell,
  input wire logic monitor_mode,
  input wire logic wake_pin,
  input wire logic charge_inhibit_disable,
  input wire bpc_pkg::bpc_thresh_t cfg_thresh,
  output logic charge_gate_out,
  output logic discharge_gate_out,
  output logic balance_out_1,
  output logic balance_out_2,
  output logic balance_out_3,
  output logic balance_out_4,
  output var bpc_pkg::bpc_gain_t sense_gain,
  output var bpc_pkg::bpc_thresh_t thresh_sel,
  output logic check_enable,
  output logic sleep_active
);

  // ********************************************************************
  // State and helper signals
  // ********************************************************************
  localparam int SW = bpc_pkg::SMP_W;
  localparam logic [SW-1:0] PERIOD_LAST = SW'(PERIOD_CYC - 1);
  localparam logic [SW-1:0] WINDOW_END = SW'(WINDOW_CYC);

  typedef struct packed {
    bpc_pkg::bpc_sync_t [bpc_pkg::PIN_COUNT-1:0] sy;
    bpc_pkg::bpc_ctl_t ctl;
    logic [7:0] wr_hi;
    bpc_pkg::bpc_frame_t frame;
    logic miso_oe;
    logic overcharge_active_flag;
    logic overdischarge_active_flag;
    logic overcurrent_active_flag;
    logic sleep;
    logic [SW-1:0] smp_cnt;
    logic check_en;
    logic charge_gate;
    logic discharge_gate;
    logic [3:0] balance;
    bpc_pkg::bpc_gain_t gain;
    bpc_pkg::bpc_thresh_t thresh;
  } bpc_state_t;

  bpc_state_t s;
  bpc_state_t next_s;
  logic [bpc_pkg::PIN_COUNT-1:0] pin_raw;
  logic [bpc_pkg::PIN_COUNT-1:0] pin;
  logic [2:0] prot_vec;
  logic prot_any;
  logic enter_ov;
  logic exit_ov;
  logic enter_uv;
  logic exit_uv;
  logic enter_oc;
  logic exit_oc;
  logic wr_commit;
  logic wake;
  logic regulator_untuned_flag;
  logic low_cell_charge_flag;
  bpc_pkg::bpc_status_t status_live;
  bpc_pkg::bpc_spi_rx_t rx;

  // ********************************************************************
  // Serial port
  // ********************************************************************
  // Byte-level slave; the status byte is offered on every byte boundary
  bpc_spi_slave u_spi (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .tx_byte(status_live),
    .spi_miso(spi_miso),
    .rx(rx)
  );

  // ********************************************************************
  // Analog flag inputs and status byte
  // ********************************************************************
  // Raw comparator and wake levels, gathered by index
  assign pin_raw[bpc_pkg::PIN_OV_TRIP] = ov_trip;
  assign pin_raw[bpc_pkg::PIN_OV_REL] = ov_release;
  assign pin_raw[bpc_pkg::PIN_UV_TRIP] = uv_trip;
  assign pin_raw[bpc_pkg::PIN_UV_REL] = uv_release;
  assign pin_raw[bpc_pkg::PIN_OC_TRIP] = oc_trip;
  assign pin_raw[bpc_pkg::PIN_OC_REL] = oc_release;
  assign pin_raw[bpc_pkg::PIN_REG_TUNED] = regulator_tuned;
  assign pin_raw[bpc_pkg::PIN_LOW_CELL] = low_cell;
  assign pin_raw[bpc_pkg::PIN_MONITOR] = monitor_mode;
  assign pin_raw[bpc_pkg::PIN_WAKE] = wake_pin;

  // Filtered values of the synchronised pins
  always_comb begin
    for (int i = 0; i < bpc_pkg::PIN_COUNT; i++) begin
      pin[i] = s.sy[i].val;
    end
  end

  // Internal flags feeding the status byte
  assign regulator_untuned_flag = !pin[bpc_pkg::PIN_REG_TUNED];
  assign low_cell_charge_flag = pin[bpc_pkg::PIN_LOW_CELL];

  // Live status, never latched or cleared by a read
  assign status_live.unused = bpc_pkg::STATUS_UNUSED;
  assign status_live.reg_oc = regulator_untuned_flag | s.overcurrent_active_flag;
  assign status_live.uv = s.overdischarge_active_flag;
  // Low-cell term only counts while charge enable is on
  assign status_live.ov_low = s.overcharge_active_flag
      | (!charge_inhibit_disable & low_cell_charge_flag);

  // ********************************************************************
  // Protection events
  // ********************************************************************
  // Voltage checks gated by the sample window, current check always live
  assign prot_vec = {s.overcharge_active_flag, s.overdischarge_active_flag,
      s.overcurrent_active_flag};
  assign prot_any = |prot_vec;
  assign enter_ov = !s.overcharge_active_flag & s.check_en & pin[bpc_pkg::PIN_OV_TRIP];
  assign exit_ov = s.overcharge_active_flag & s.check_en & pin[bpc_pkg::PIN_OV_REL];
  assign enter_uv = !s.overdischarge_active_flag & s.check_en & pin[bpc_pkg::PIN_UV_TRIP];
  assign exit_uv = s.overdischarge_active_flag & s.check_en & pin[bpc_pkg::PIN_UV_REL];
  assign enter_oc = !s.overcurrent_active_flag & pin[bpc_pkg::PIN_OC_TRIP];
  assign exit_oc = s.overcurrent_active_flag & pin[bpc_pkg::PIN_OC_REL];

  // Command decode helpers
  assign wr_commit = rx.valid && (s.frame == bpc_pkg::FR_WR_LO);
  assign wake = s.sleep && pin[bpc_pkg::PIN_WAKE];

  // ********************************************************************
  // Next-state logic
  // ********************************************************************
  always_comb begin
    next_s = s;
    for (int i = 0; i < bpc_pkg::PIN_COUNT; i++) begin
      next_s.sy[i] = bpc_pkg::bpc_sync_step(s.sy[i], pin_raw[i]);
    end

    // Frame decoder: command byte, then data bytes
    if (!rx.active) begin
      next_s.frame = bpc_pkg::FR_CMD;
      next_s.miso_oe = 1'h0;
    end else if (rx.valid) begin
      unique case (s.frame)
        bpc_pkg::FR_CMD: begin
          if (rx.data == bpc_pkg::CMD_WRITE_CTL) begin
            next_s.frame = bpc_pkg::FR_WR_HI;
          end else if (rx.data == bpc_pkg::CMD_READ_STATUS) begin
            next_s.frame = bpc_pkg::FR_READ;
            next_s.miso_oe = 1'h1;
          end else begin
            next_s.frame = bpc_pkg::FR_SKIP;
          end
        end
        bpc_pkg::FR_WR_HI: begin
          next_s.wr_hi = rx.data;
          next_s.frame = bpc_pkg::FR_WR_LO;
        end
        bpc_pkg::FR_WR_LO: begin
          // Upper byte holds gain, FET and balance fields
          next_s.ctl = bpc_pkg::bpc_ctl_t'({s.wr_hi, rx.data[7], 7'h00});
          next_s.frame = bpc_pkg::FR_SKIP;
        end
        bpc_pkg::FR_READ: begin
          next_s.miso_oe = 1'h0;
          next_s.frame = bpc_pkg::FR_SKIP;
        end
        bpc_pkg::FR_SKIP: begin
          next_s.frame = bpc_pkg::FR_SKIP;
        end
        default: begin
          next_s.frame = bpc_pkg::FR_SKIP;
        end
      endcase
    end

    // Sample rate timer and voltage check enable
    next_s.smp_cnt = (s.smp_cnt == PERIOD_LAST) ? '0 : s.smp_cnt + SW'(1);
    next_s.check_en = (s.smp_cnt < WINDOW_END) | pin[bpc_pkg::PIN_MONITOR];

    // Protection mode flags
    if (enter_ov) begin
      next_s.overcharge_active_flag = 1'h1;
    end else if (exit_ov) begin
      next_s.overcharge_active_flag = 1'h0;
    end
    if (enter_uv) begin
      next_s.overdischarge_active_flag = 1'h1;
    end else if (exit_uv) begin
      next_s.overdischarge_active_flag = 1'h0;
    end
    if (enter_oc) begin
      next_s.overcurrent_active_flag = 1'h1;
    end else if (exit_oc) begin
      next_s.overcurrent_active_flag = 1'h0;
    end

    // FET gates follow control only outside protection
    if (!prot_any && !enter_ov && !enter_uv && !enter_oc) begin
      next_s.charge_gate = !s.ctl.charge_fet_ctl;
      next_s.discharge_gate = !s.ctl.discharge_fet_ctl;
    end
    // Entry forces the affected FET off
    if (enter_ov) begin
      next_s.charge_gate = bpc_pkg::GATE_OFF;
    end
    if (enter_uv || enter_oc) begin
      next_s.discharge_gate = bpc_pkg::GATE_OFF;
    end

    // Balance, gain and threshold selections
    next_s.balance = {s.ctl.balance_ctl_4, s.ctl.balance_ctl_3,
        s.ctl.balance_ctl_2, s.ctl.balance_ctl_1};
    next_s.gain = bpc_pkg::bpc_gain_t'({s.ctl.sense_gain_hi, s.ctl.sense_gain_lo});
    next_s.thresh = cfg_thresh;

    // Sleep entry by request or over-discharge; wake clears control
    if ((wr_commit && rx.data[7]) || enter_uv) begin
      next_s.sleep = 1'h1;
    end
    if (wake) begin
      next_s.sleep = 1'h0;
      next_s.ctl = bpc_pkg::CTL_RESET;
    end
  end

  // State register with constant reset values
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.ctl <= bpc_pkg::CTL_RESET;
      s.frame <= bpc_pkg::FR_CMD;
      s.gain <= bpc_pkg::GAIN_X10;
      s.charge_gate <= bpc_pkg::GATE_OFF;
      s.discharge_gate <= bpc_pkg::GATE_OFF;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state
  assign spi_miso_oe = s.miso_oe;
  assign charge_gate_out = s.charge_gate;
  assign discharge_gate_out = s.discharge_gate;
  assign balance_out_1 = s.balance[0];
  assign balance_out_2 = s.balance[1];
  assign balance_out_3 = s.balance[2];
  assign balance_out_4 = s.balance[3];
  assign sense_gain = s.gain;
  assign thresh_sel = s.thresh;
  assign check_enable = s.check_en;
  assign sleep_active = s.sleep;

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_free;
    !prot_any ##1 !prot_any;
  endsequence

  sequence s_read_cmd;
    rx.valid && (s.frame == bpc_pkg::FR_CMD) && (rx.data == bpc_pkg::CMD_READ_STATUS);
  endsequence

  property p_gain;
    wr_commit |=> ##1 (sense_gain == $past(s.wr_hi[1:0], 2));
  endproperty
  a_gain: assert property (p_gain) else $error("gain output wrong after write");

  property p_charge;
    s_free |-> (charge_gate_out == !$past(s.ctl.charge_fet_ctl));
  endproperty
  a_charge: assert property (p_charge) else $error("charge gate not following bit");

  property p_discharge;
    s_free |-> (discharge_gate_out == !$past(s.ctl.discharge_fet_ctl));
  endproperty
  a_discharge: assert property (p_discharge) else $error("discharge gate wrong");

  property p_hold;
    (prot_any && $stable(prot_vec)) |-> $stable({charge_gate_out, discharge_gate_out});
  endproperty
  a_hold: assert property (p_hold) else $error("gate moved during protection");

  property p_entry;
    $rose(s.overcharge_active_flag) |-> (charge_gate_out == bpc_pkg::GATE_OFF);
  endproperty
  a_entry: assert property (p_entry) else $error("charge FET not off on entry");

  property p_balance;
    wr_commit |=> ##1 ({balance_out_4, balance_out_3, balance_out_2, balance_out_1}
        == $past(s.wr_hi[7:4], 2));
  endproperty
  a_balance: assert property (p_balance) else $error("balance outputs wrong");

  property p_read;
    s_read_cmd |=> spi_miso_oe;
  endproperty
  a_read: assert property (p_read) else $error("read command not answered");

  property p_status_top;
    $rose(spi_miso_oe) |-> !spi_miso [*8];
  endproperty
  a_status_top: assert property (p_status_top) else $error("status bit 7 not zero");

  property p_window;
    (!pin[bpc_pkg::PIN_MONITOR] && (s.smp_cnt >= WINDOW_END)) |=> !check_enable;
  endproperty
  a_window: assert property (p_window) else $error("check enabled outside window");

  property p_ov_gate;
    (!s.check_en && !s.overcharge_active_flag) |=> !s.overcharge_active_flag;
  endproperty
  a_ov_gate: assert property (p_ov_gate) else $error("over-charge entered unsampled");

  property p_oc;
    (pin[bpc_pkg::PIN_OC_TRIP] && !s.overcurrent_active_flag) |=> s.overcurrent_active_flag;
  endproperty
  a_oc: assert property (p_oc) else $error("over-current not entered");

  property p_wake;
    wake |=> ((s.ctl == bpc_pkg::CTL_RESET) && !sleep_active);
  endproperty
  a_wake: assert property (p_wake) else $error("control not cleared on wake");

endmodule : bpc_top
`default_nettype wire

/* bpc_pkg.sv */
// Shared constants and types of the pack protector control and status block
// Notes on behaviour
// - Gain code 00/01/10/11 selects x10/x25/x80/x160
// - Charge gate low when its bit set
// - Discharge gate low when its bit set
// - Gate outputs frozen during protection, except that another mode's entry forces its FET off
// - Balance outputs follow their control bits
// - Read command returns the status byte
// - Status bit 0: untuned OR over-current
// - Regulator flag high until regulator tuned
// - Status bit 1: over-discharge mode active
// - Charge-enable on: bit 2 low-cell OR over-charge
// - Charge-enable off: bit 2 over-charge only
// - Status bits 3 to 7 read zero
// - Voltage checks periodic, over-current check continuous
// - Entry switches FET off, release restores it
// - Monitor mode makes voltage checks continuous
// - Thresholds come from configuration storage selections
// - Control register zero at reset and wake
// - Gain 9:8, charge 10, discharge 11, balance 15:12
// - Voltage checks on 2 ms per 125 ms
package bpc_pkg;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int unsigned CLK_KHZ = 100_000;
  localparam int unsigned SAMPLE_PERIOD_MS = 125;
  localparam int unsigned SAMPLE_WINDOW_MS = 2;
  localparam int unsigned SAMPLE_PERIOD_CYC = SAMPLE_PERIOD_MS * CLK_KHZ;
  localparam int unsigned SAMPLE_WINDOW_CYC = SAMPLE_WINDOW_MS * CLK_KHZ;
  localparam int SMP_W = 24;

  // ********************************************************************
  // Commands, reset values, pin indices
  // ********************************************************************
  localparam logic [7:0] CMD_WRITE_CTL = 8'h02;
  localparam logic [7:0] CMD_READ_STATUS = 8'h05;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam logic GATE_OFF = 1'h1; // High gate keeps the P-channel FET off
  localparam logic CS_IDLE = 1'h1;
  localparam logic [4:0] STATUS_UNUSED = 5'h00;
  localparam int PIN_OV_TRIP = 0;
  localparam int PIN_OV_REL = 1;
  localparam int PIN_UV_TRIP = 2;
  localparam int PIN_UV_REL = 3;
  localparam int PIN_OC_TRIP = 4;
  localparam int PIN_OC_REL = 5;
  localparam int PIN_REG_TUNED = 6;
  localparam int PIN_LOW_CELL = 7;
  localparam int PIN_MONITOR = 8;
  localparam int PIN_WAKE = 9;
  localparam int PIN_COUNT = 10;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [1:0] {
    GAIN_X10 = 2'h0,
    GAIN_X25 = 2'h1,
    GAIN_X80 = 2'h2,
    GAIN_X160 = 2'h3
  } bpc_gain_t;

  typedef enum logic [2:0] {
    FR_CMD = 3'h0,
    FR_WR_HI = 3'h1,
    FR_WR_LO = 3'h3,
    FR_SKIP = 3'h7,
    FR_READ = 3'h2
  } bpc_frame_t;

  typedef struct packed {
    logic balance_ctl_4;
    logic balance_ctl_3;
    logic balance_ctl_2;
    logic balance_ctl_1;
    logic discharge_fet_ctl;
    logic charge_fet_ctl;
    logic sense_gain_hi;
    logic sense_gain_lo;
    logic sleep_request;
    logic [6:0] unused;
  } bpc_ctl_t;

  typedef struct packed {
    logic [4:0] unused;
    logic ov_low;
    logic uv;
    logic reg_oc;
  } bpc_status_t;

  typedef struct packed {
    logic [1:0] ov_sel;
    logic [1:0] uv_sel;
    logic [1:0] oc_sel;
  } bpc_thresh_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic val;
  } bpc_sync_t;

  typedef struct packed {
    logic active;
    logic valid;
    logic [7:0] data;
  } bpc_spi_rx_t;

  // Three-stage synchroniser step; a change counts once stages two and three agree
  function automatic bpc_sync_t bpc_sync_step(input bpc_sync_t q, input logic pin);
    bpc_sync_t r;
    r.s1 = pin;
    r.s2 = q.s1;
    r.s3 = q.s2;
    r.val = (q.s2 == q.s3) ? q.s3 : q.val;
    return r;
  endfunction : bpc_sync_step

endpackage : bpc_pkg

/* bpc_spi_slave.sv */
// Serial peripheral port slave, mode 0, sampled by the system clock
`timescale 1ns/1ns
`default_nettype none
module bpc_spi_slave (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic [7:0] tx_byte,
  output logic spi_miso,
  output var bpc_pkg::bpc_spi_rx_t rx
);

  typedef struct packed {
    bpc_pkg::bpc_sync_t sck;
    bpc_pkg::bpc_sync_t cs_n;
    bpc_pkg::bpc_sync_t mosi;
    logic sck_prev;
    logic [2:0] bit_cnt;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic hold;
    bpc_pkg::bpc_spi_rx_t rx;
  } bpc_spis_t;

  bpc_spis_t s;
  bpc_spis_t next_s;

  // Edge detection, shifting in on rising and out on falling clock edges
  always_comb begin
    next_s = s;
    next_s.sck = bpc_pkg::bpc_sync_step(s.sck, spi_sck);
    next_s.cs_n = bpc_pkg::bpc_sync_step(s.cs_n, spi_cs_n);
    next_s.mosi = bpc_pkg::bpc_sync_step(s.mosi, spi_mosi);
    next_s.sck_prev = s.sck.val;
    next_s.rx.valid = 1'h0;
    next_s.rx.active = !s.cs_n.val;
    if (s.cs_n.val) begin
      next_s.bit_cnt = 3'h0;
      next_s.hold = 1'h0;
      next_s.tx_sh = 8'h00;
    end else if (s.sck.val && !s.sck_prev) begin
      next_s.rx_sh = {s.rx_sh[6:0], s.mosi.val};
      next_s.bit_cnt = s.bit_cnt + 3'h1;
      if (s.bit_cnt == 3'h7) begin
        next_s.rx.valid = 1'h1;
        next_s.rx.data = {s.rx_sh[6:0], s.mosi.val};
        next_s.tx_sh = tx_byte; // Captured at the last sampling edge
        next_s.hold = 1'h1;
      end
    end else if (!s.sck.val && s.sck_prev) begin
      // The first falling edge after a load keeps bit 7 on the line
      if (s.hold) begin
        next_s.hold = 1'h0;
      end else begin
        next_s.tx_sh = {s.tx_sh[6:0], 1'h0};
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.cs_n <= {4{bpc_pkg::CS_IDLE}};
    end else begin
      s <= next_s;
    end
  end

  assign spi_miso = s.tx_sh[7];
  assign rx = s.rx;

endmodule : bpc_spi_slave
`default_nettype wire

/* bpc_host_model.sv */
// Host serial master model driving the protector serial port in mode 0
`timescale 1ns/1ns
`default_nettype none
module bpc_host_model #(
  parameter int HALF_NS = 80
) (
  output var logic spi_sck,
  output var logic spi_cs_n,
  output var logic spi_mosi,
  input wire logic spi_miso,
  input wire logic spi_miso_oe
);
  logic last_bit;
  wire logic miso_line;

  // A released data line shows the inverse of its last level
  assign miso_line = spi_miso_oe ? spi_miso : ~last_bit;

  // Idle levels at time zero, serial clock stands low
  initial begin
    spi_sck = 1'h0;
    spi_cs_n = 1'h1;
    spi_mosi = 1'h0;
    last_bit = 1'h0;
  end

  // One byte, MSB first, data set while clock low and sampled on the rise
  task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spi_mosi = tx[i];
      #HALF_NS spi_sck = 1'h1;
      rx[i] = miso_line;
      last_bit = miso_line;
      #HALF_NS spi_sck = 1'h0;
    end
  endtask : xfer_byte

  // Whole frame of n bytes; the second byte's reply is handed back
  task automatic frame(input int n, input logic [7:0] b0, input logic [7:0] b1,
    input logic [7:0] b2, output logic [7:0] r1);
    logic [7:0] rx;
    r1 = 8'h00;
    spi_cs_n = 1'h0;
    #HALF_NS;
    xfer_byte(b0, rx);
    if (n > 1) xfer_byte(b1, r1);
    if (n > 2) xfer_byte(b2, rx);
    #HALF_NS spi_cs_n = 1'h1;
    spi_mosi = ~spi_mosi;
    #HALF_NS;
  endtask : frame
endmodule : bpc_host_model
`default_nettype wire

/* bpc_top_tb.sv */
// Self-checking bench of the pack protector control and status block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module bpc_top_tb;
  logic sys_clk = 1'h0;
  logic arst_n = 1'h0;
  logic spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic ov_trip = 1'h0, ov_release = 1'h0, uv_trip = 1'h0, uv_release = 1'h0;
  logic oc_trip = 1'h0, oc_release = 1'h0, regulator_tuned = 1'h0, low_cell = 1'h0;
  logic monitor_mode = 1'h0, wake_pin = 1'h0, charge_inhibit_disable = 1'h1;
  bpc_pkg::bpc_thresh_t cfg_thresh = 6'h00;
  bpc_pkg::bpc_thresh_t thresh_sel;
  bpc_pkg::bpc_gain_t sense_gain;
  logic charge_gate_out, discharge_gate_out, check_enable, sleep_active;
  logic balance_out_1, balance_out_2, balance_out_3, balance_out_4;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] lf = 8'h1a;
  logic [7:0] hi, st, fl;
  logic [31:0] cnt;

  // ********************************************************************
  // Clock, partner and design
  // ********************************************************************
  always #5 sys_clk = ~sys_clk;

  bpc_host_model host_u (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));

  bpc_top #(.PERIOD_CYC(100), .WINDOW_CYC(10)) dut_u (.sys_clk(sys_clk), .arst_n(arst_n),
    .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .ov_trip(ov_trip), .ov_release(ov_release),
    .uv_trip(uv_trip), .uv_release(uv_release), .oc_trip(oc_trip),
    .oc_release(oc_release), .regulator_tuned(regulator_tuned), .low_cell(low_cell),
    .monitor_mode(monitor_mode), .wake_pin(wake_pin),
    .charge_inhibit_disable(charge_inhibit_disable), .cfg_thresh(cfg_thresh),
    .charge_gate_out(charge_gate_out), .discharge_gate_out(discharge_gate_out),
    .balance_out_1(balance_out_1), .balance_out_2(balance_out_2),
    .balance_out_3(balance_out_3), .balance_out_4(balance_out_4),
    .sense_gain(sense_gain), .thresh_sel(thresh_sel), .check_enable(check_enable),
    .sleep_active(sleep_active));

  // ********************************************************************
  // Helpers
  // ********************************************************************
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr

  // Expected status byte from the live flags
  function automatic logic [7:0] exp_stat(input logic ov, input logic uv, input logic oc);
    return {5'h00, ov | (low_cell & ~charge_inhibit_disable), uv, ~regulator_tuned | oc};
  endfunction : exp_stat

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic wr_ctl(input logic [7:0] v, input int n, input logic [7:0] cmd);
    logic [7:0] r;
    host_u.frame(n, cmd, v, 8'h00, r);
    tick(4);
  endtask : wr_ctl

  task automatic chk_st(input logic ov, input logic uv, input logic oc);
    host_u.frame(2, bpc_pkg::CMD_READ_STATUS, lf, 8'h00, st);
    `CHK("status", exp_stat(ov, uv, oc), st)
  endtask : chk_st

  // Outputs against a control byte; gates given as {discharge, charge}
  task automatic chk_ctl(input logic [7:0] v, input logic [1:0] g);
    logic [3:0] b;
    b = {balance_out_4, balance_out_3, balance_out_2, balance_out_1};
    `CHK("gain", v[1:0], sense_gain)
    `CHK("charge_gate", g[0], charge_gate_out)
    `CHK("discharge_gate", g[1], discharge_gate_out)
    `CHK("balance", v[7:4], b)
  endtask : chk_ctl

  task automatic duty(input logic [31:0] e);
    cnt = 32'h0;
    repeat (100) begin
      tick(1);
      cnt = cnt + check_enable;
    end
    `CHK("check_enable", e, cnt)
  endtask : duty

  task automatic results;
    if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      results();
    end
  end

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    repeat (10) @(posedge sys_clk);
    #1 arst_n = 1'h1;
    tick(10);
    chk_ctl(8'h00, 2'h3);
    chk_st(1'h0, 1'h0, 1'h0);
    duty(32'h0000000a);
    monitor_mode = 1'h1;
    tick(6);
    duty(32'h00000064);
    monitor_mode = 1'h0;
    for (int k = 0; k < 10; k++) begin
      lf = lfsr(lf);
      hi = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : lf;
      lf = lfsr(lf);
      fl = lf;
      regulator_tuned = fl[0];
      low_cell = fl[1];
      charge_inhibit_disable = fl[2];
      cfg_thresh = fl[7:2];
      wr_ctl(hi, 3, bpc_pkg::CMD_WRITE_CTL);
      chk_ctl(hi, {~hi[3], ~hi[2]});
      `CHK("thresh_sel", cfg_thresh, thresh_sel)
      chk_st(1'h0, 1'h0, 1'h0);
    end
    regulator_tuned = 1'h1;
    low_cell = 1'h1;
    charge_inhibit_disable = 1'h1;
    // Lost frame and unknown command leave the outputs alone
    wr_ctl(~hi, 2, bpc_pkg::CMD_WRITE_CTL);
    wr_ctl(~hi, 3, 8'h33);
    chk_ctl(hi, {~hi[3], ~hi[2]});
    // Over-charge: charge FET off, FET bits of writes held back until release
    wr_ctl(8'h0c, 3, bpc_pkg::CMD_WRITE_CTL);
    ov_trip = 1'h1;
    tick(120);
    ov_trip = 1'h0;
    chk_ctl(8'h0c, 2'h1);
    chk_st(1'h1, 1'h0, 1'h0);
    wr_ctl(8'h17, 3, bpc_pkg::CMD_WRITE_CTL);
    chk_ctl(8'h17, 2'h1);
    ov_release = 1'h1;
    tick(120);
    ov_release = 1'h0;
    chk_ctl(8'h17, 2'h2);
    // Over-current acts at any cycle
    wr_ctl(8'h0c, 3, bpc_pkg::CMD_WRITE_CTL);
    oc_trip = 1'h1;
    tick(8);
    oc_trip = 1'h0;
    chk_ctl(8'h0c, 2'h2);
    chk_st(1'h0, 1'h0, 1'h1);
    oc_release = 1'h1;
    tick(8);
    oc_release = 1'h0;
    chk_ctl(8'h0c, 2'h0);
    // Over-discharge enters sleep; wake clears the control register
    uv_trip = 1'h1;
    tick(120);
    uv_trip = 1'h0;
    `CHK("sleep", 1'h1, sleep_active)
    chk_ctl(8'h0c, 2'h2);
    chk_st(1'h0, 1'h1, 1'h0);
    uv_release = 1'h1;
    tick(120);
    uv_release = 1'h0;
    wake_pin = 1'h1;
    tick(8);
    wake_pin = 1'h0;
    tick(2);
    `CHK("sleep", 1'h0, sleep_active)
    chk_ctl(8'h00, 2'h3);
    // Sleep request bit of the lower byte enters sleep, outputs stay put
    host_u.frame(3, bpc_pkg::CMD_WRITE_CTL, 8'h00, 8'h80, st);
    tick(4);
    `CHK("sleep", 1'h1, sleep_active)
    chk_ctl(8'h00, 2'h3);
    results();
  end
endmodule : bpc_top_tb
`default_nettype wire
